// ==== core/mhb_pkg.sv ====
// Purpose: Constants for the hash filter, backoff, pacing and pause block
// Assumes: One 250 MHz clock, synchronous active-high reset
// Notes:   Register offsets are byte addresses on the AXI4-Lite bus
//
// What this block does
// - Hash index XORs address bits k, k+6, ...
// - Low table word holds indexes 0..31
// - High table word holds indexes 32..63
// - Group frame accepted when its table bit set
// - Random generator clears on reset, then advances
// - Random field read returns live undisturbed value
// - Four-bit collision count for current frame
// - Backoff counter loads after collision, readable
// - Backoff counter drops one per slot time
// - Collision or deferral loads pacing with 31
// - Clean frame decrements pacing, floor zero
// - Pacing active while pacing counter nonzero
// - Active pacing stretches gap to four gaps
// - Deferred or collided frame uses normal gap
// - Sent pause frame loads pause timer 0xff00
// - Pause timer drops one per slot time
// - Pause timer at zero sends another pause
// - Pause timer in low 16 bits, upper zero

package mhb_pkg;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [7:0]  HASH_LO_OFS    = 8'h00;
	localparam logic [7:0]  HASH_HI_OFS    = 8'h04;
	localparam logic [7:0]  BOFF_OBS_OFS   = 8'h08;
	localparam logic [7:0]  PACE_OBS_OFS   = 8'h0c;
	localparam logic [7:0]  PAUSE_OBS_OFS  = 8'h10;
	localparam logic [7:0]  CTRL_OFS       = 8'h14;
	localparam int          ADDR_W         = 8;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int          RND_LSB        = 16;
	localparam int          COLL_LSB       = 12;
	localparam int          BOFF_LSB       = 0;
	localparam int          PACE_LSB       = 0;
	localparam int          PAUSE_LSB      = 0;
	localparam int          CTRL_FLOW_BIT  = 0;

	// ****************************************************************
	// Widths, reset and load values
	// ****************************************************************
	localparam int          RND_W          = 10;
	localparam int          COLL_W         = 4;
	localparam int          PACE_W         = 5;
	localparam int          PAUSE_W        = 16;
	localparam logic [31:0] HASH_RST       = 32'h0000_0000;
	localparam logic [9:0]  RND_RST        = 10'h000;
	localparam logic [4:0]  PACE_LOAD      = 5'h1f;
	localparam logic [15:0] PAUSE_LOAD     = 16'hff00;
	localparam logic [3:0]  COLL_MAX       = 4'hf;
	localparam int          SLOT_BITS      = 512;

	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;

endpackage : mhb_pkg

// ==== core/mhb_top.sv ====
// Purpose: Multicast hash filter, collision backoff, transmit pacing and
//          receive pause timer of an Ethernet MAC, with AXI4-Lite access
// Assumes: All inputs synchronous to core_clk; tx_bit_tick pulses once
//          per bit time of the current line rate
// Notes:   Event inputs are one-cycle pulses

`timescale 1ns/1ns

module mhb_top #(
	parameter int SLOT_BITS = mhb_pkg::SLOT_BITS
) (
	input  wire logic        core_clk,
	input  wire logic        srst,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [7:0]  s_axi_araddr,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	input  wire logic [47:0] rx_dest_addr,
	input  wire logic        rx_addr_valid,
	output logic             rx_hash_accept,
	output logic [5:0]       rx_hash_index,
	input  wire logic        tx_bit_tick,
	input  wire logic        tx_collision,
	input  wire logic        tx_deferral,
	input  wire logic        tx_frame_good,
	input  wire logic        tx_frame_done,
	output logic             backoff_active,
	output logic             pacing_active,
	output logic             ipg_stretch,
	input  wire logic        rx_congested,
	input  wire logic        pause_frame_sent,
	output logic             pause_frame_req
);

	// ****************************************************************
	// Functions
	// ****************************************************************
	function automatic logic [5:0] hash_fn(input logic [47:0] da);
		logic [5:0] h;
		h = 6'h00;
		for (int i = 0; i < 48; i++) begin
			h[i % 6] = h[i % 6] ^ da[i];
		end
		return h;
	endfunction : hash_fn

	// Window widens with each collision, capped at ten bits
	function automatic logic [9:0] boff_mask(input logic [3:0] n);
		logic [9:0] m;
		m = 10'h000;
		for (int i = 0; i < 10; i++) begin
			m[i] = (4'(i) < n);
		end
		return m;
	endfunction : boff_mask

	localparam int SC_W = $clog2(SLOT_BITS);

	logic [31:0]  hash_lo_q;
	logic [31:0]  hash_hi_q;
	logic         flow_en_q;
	logic [9:0]   rnd_q;
	logic [3:0]   coll_q;
	logic [9:0]   boff_q;
	logic [4:0]   pace_q;
	logic         last_clean_q;
	logic [15:0]  pause_q;
	logic         pause_req_q;
	logic [SC_W-1:0] slot_cnt_q;
	logic         slot_tick;
	logic         hash_acc_q;
	logic [5:0]   hash_idx_q;
	logic [63:0]  hash_tbl;

	// ****************************************************************
	// AXI4-Lite slave
	// ****************************************************************
	logic         aw_full_q;
	logic [7:0]   aw_addr_q;
	logic         w_full_q;
	logic [31:0]  w_data_q;
	logic [3:0]   w_strb_q;
	logic         bvalid_q;
	logic [1:0]   bresp_q;
	logic         rvalid_q;
	logic [31:0]  rdata_q;
	logic [1:0]   rresp_q;
	logic         wr_go;
	logic         rd_go;
	logic [31:0]  rd_val;
	logic         rd_hit;

	assign s_axi_awready = !aw_full_q;
	assign s_axi_wready  = !w_full_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;
	assign wr_go = aw_full_q && w_full_q && !bvalid_q;
	assign rd_go = s_axi_arvalid && !rvalid_q;

	always_ff @(posedge core_clk) begin
		if (srst) begin
			aw_full_q <= 1'b0;
			aw_addr_q <= 8'h00;
		end else if (s_axi_awvalid && !aw_full_q) begin
			aw_full_q <= 1'b1;
			aw_addr_q <= s_axi_awaddr;
		end else if (wr_go) begin
			aw_full_q <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			w_full_q <= 1'b0;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
		end else if (s_axi_wvalid && !w_full_q) begin
			w_full_q <= 1'b1;
			w_data_q <= s_axi_wdata;
			w_strb_q <= s_axi_wstrb;
		end else if (wr_go) begin
			w_full_q <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			bvalid_q <= 1'b0;
			bresp_q  <= mhb_pkg::RESP_OKAY;
		end else if (wr_go) begin
			bvalid_q <= 1'b1;
			unique case (aw_addr_q)
				mhb_pkg::HASH_LO_OFS, mhb_pkg::HASH_HI_OFS,
				mhb_pkg::CTRL_OFS: bresp_q <= mhb_pkg::RESP_OKAY;
				default:           bresp_q <= mhb_pkg::RESP_SLVERR;
			endcase
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// Observation words are assembled live so a read sees this cycle
	always_comb begin
		rd_val = 32'h0000_0000;
		rd_hit = 1'b1;
		unique case (s_axi_araddr)
			mhb_pkg::HASH_LO_OFS:   rd_val = hash_lo_q;
			mhb_pkg::HASH_HI_OFS:   rd_val = hash_hi_q;
			mhb_pkg::BOFF_OBS_OFS: begin
				rd_val[mhb_pkg::RND_LSB +: mhb_pkg::RND_W] = rnd_q;
				rd_val[mhb_pkg::COLL_LSB +: mhb_pkg::COLL_W] = coll_q;
				rd_val[mhb_pkg::BOFF_LSB +: mhb_pkg::RND_W] = boff_q;
			end
			mhb_pkg::PACE_OBS_OFS:
				rd_val[mhb_pkg::PACE_LSB +: mhb_pkg::PACE_W] = pace_q;
			mhb_pkg::PAUSE_OBS_OFS:
				rd_val[mhb_pkg::PAUSE_LSB +: mhb_pkg::PAUSE_W] = pause_q;
			mhb_pkg::CTRL_OFS:
				rd_val[mhb_pkg::CTRL_FLOW_BIT] = flow_en_q;
			default:                rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= mhb_pkg::RESP_OKAY;
		end else if (rd_go) begin
			rvalid_q <= 1'b1;
			rdata_q  <= rd_val;
			rresp_q  <= rd_hit ? mhb_pkg::RESP_OKAY : mhb_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// ****************************************************************
	// Writable registers
	// ****************************************************************
	always_ff @(posedge core_clk) begin
		if (srst) begin
			hash_lo_q <= mhb_pkg::HASH_RST;
			hash_hi_q <= mhb_pkg::HASH_RST;
			flow_en_q <= 1'b0;
		end else if (wr_go) begin
			for (int b = 0; b < 4; b++) begin
				if (w_strb_q[b] && aw_addr_q == mhb_pkg::HASH_LO_OFS) begin
					hash_lo_q[b*8 +: 8] <= w_data_q[b*8 +: 8];
				end
				if (w_strb_q[b] && aw_addr_q == mhb_pkg::HASH_HI_OFS) begin
					hash_hi_q[b*8 +: 8] <= w_data_q[b*8 +: 8];
				end
			end
			if (w_strb_q[0] && aw_addr_q == mhb_pkg::CTRL_OFS) begin
				flow_en_q <= w_data_q[mhb_pkg::CTRL_FLOW_BIT];
			end
		end
	end

	// ****************************************************************
	// Multicast hash filter
	// ****************************************************************
	assign hash_tbl = {hash_hi_q, hash_lo_q};

	// Unicast frames never pass here; the address match decides those
	always_ff @(posedge core_clk) begin
		if (srst) begin
			hash_acc_q <= 1'b0;
			hash_idx_q <= 6'h00;
		end else begin
			hash_acc_q <= rx_addr_valid && rx_dest_addr[0] &&
				hash_tbl[hash_fn(rx_dest_addr)];
			if (rx_addr_valid) begin
				hash_idx_q <= hash_fn(rx_dest_addr);
			end
		end
	end

	assign rx_hash_accept = hash_acc_q;
	assign rx_hash_index  = hash_idx_q;

	// ****************************************************************
	// Slot timer
	// ****************************************************************
	assign slot_tick = tx_bit_tick && (slot_cnt_q == SC_W'(SLOT_BITS - 1));

	// Restarting on a collision aligns backoff slots to the collision
	always_ff @(posedge core_clk) begin
		if (srst || tx_collision) begin
			slot_cnt_q <= '0;
		end else if (slot_tick) begin
			slot_cnt_q <= '0;
		end else if (tx_bit_tick) begin
			slot_cnt_q <= slot_cnt_q + SC_W'(1);
		end
	end

	// ****************************************************************
	// Backoff
	// ****************************************************************
	// XNOR feedback so the all-zero reset value is not a lock-up state
	always_ff @(posedge core_clk) begin
		if (srst) begin
			rnd_q <= mhb_pkg::RND_RST;
		end else begin
			rnd_q <= {rnd_q[8:0], ~(rnd_q[9] ^ rnd_q[6])};
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst || tx_frame_done) begin
			coll_q <= 4'h0;
		end else if (tx_collision && coll_q != mhb_pkg::COLL_MAX) begin
			coll_q <= coll_q + 4'h1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			boff_q <= 10'h000;
		end else if (tx_collision) begin
			boff_q <= rnd_q & boff_mask(coll_q == mhb_pkg::COLL_MAX ?
				coll_q : coll_q + 4'h1);
		end else if (slot_tick && boff_q != 10'h000) begin
			boff_q <= boff_q - 10'h001;
		end
	end

	assign backoff_active = (boff_q != 10'h000);

	// ****************************************************************
	// Transmit pacing
	// ****************************************************************
	always_ff @(posedge core_clk) begin
		if (srst) begin
			pace_q <= 5'h00;
		end else if (tx_collision || tx_deferral) begin
			pace_q <= mhb_pkg::PACE_LOAD;
		end else if (tx_frame_good && pace_q != 5'h00) begin
			pace_q <= pace_q - 5'h01;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst || tx_collision || tx_deferral) begin
			last_clean_q <= 1'b0;
		end else if (tx_frame_good) begin
			last_clean_q <= 1'b1;
		end
	end

	assign pacing_active = (pace_q != 5'h00);
	// The gap logic uses four gaps while this is high
	assign ipg_stretch = pacing_active && last_clean_q;

	// ****************************************************************
	// Receive pause timer
	// ****************************************************************
	always_ff @(posedge core_clk) begin
		if (srst) begin
			pause_q <= 16'h0000;
		end else if (pause_frame_sent) begin
			pause_q <= mhb_pkg::PAUSE_LOAD;
		end else if (slot_tick && pause_q != 16'h0000) begin
			pause_q <= pause_q - 16'h0001;
		end
	end

	// Held until the transmitter sends or flow control is switched off
	always_ff @(posedge core_clk) begin
		if (srst || pause_frame_sent || !flow_en_q) begin
			pause_req_q <= 1'b0;
		end else if (rx_congested && pause_q == 16'h0000) begin
			pause_req_q <= 1'b1;
		end
	end

	assign pause_frame_req = pause_req_q;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	sequence pause_expires;
		slot_tick && pause_q == 16'h0001 && !pause_frame_sent;
	endsequence

	sequence still_wanted;
		flow_en_q && rx_congested && !pause_frame_sent;
	endsequence

	AST_HASH_INDEX: assert property (
		rx_addr_valid |=> rx_hash_index == hash_fn($past(rx_dest_addr)))
		else $error("Hash index wrong");
	AST_HASH_ACCEPT: assert property (
		rx_addr_valid && rx_dest_addr[0] |=> rx_hash_accept ==
		$past(hash_tbl[hash_fn(rx_dest_addr)]))
		else $error("Hash accept wrong");
	AST_RND_RUNS: assert property (
		!$past(srst) |-> rnd_q != $past(rnd_q))
		else $error("Random generator stalled");
	AST_RND_READ: assert property (
		rd_go && s_axi_araddr == mhb_pkg::BOFF_OBS_OFS |=>
		s_axi_rdata[25:16] == $past(rnd_q))
		else $error("Random read wrong");
	AST_COLL_COUNT: assert property (
		tx_collision && !tx_frame_done && coll_q != 4'hf |=>
		coll_q == $past(coll_q) + 4'h1)
		else $error("Collision count wrong");
	AST_BOFF_LOAD: assert property (
		tx_collision && coll_q < 4'h9 |=>
		(boff_q & ~boff_mask($past(coll_q) + 4'h1)) == 10'h000)
		else $error("Backoff load out of window");
	AST_BOFF_DEC: assert property (
		slot_tick && !tx_collision && boff_q != 10'h000 |=>
		boff_q == $past(boff_q) - 10'h001)
		else $error("Backoff decrement wrong");
	AST_PACE_LOAD: assert property (
		tx_collision || tx_deferral |=> pace_q == 5'h1f &&
		pacing_active && !ipg_stretch)
		else $error("Pacing load wrong");
	AST_PACE_DEC: assert property (
		tx_frame_good && !tx_collision && !tx_deferral && pace_q > 5'h00
		|=> pace_q == $past(pace_q) - 5'h01)
		else $error("Pacing decrement wrong");
	AST_STRETCH: assert property (
		tx_frame_good && !tx_collision && !tx_deferral && pace_q > 5'h01
		|=> ipg_stretch) else $error("Gap not stretched");
	AST_PAUSE_LOAD: assert property (
		pause_frame_sent |=> pause_q == 16'hff00)
		else $error("Pause load wrong");
	AST_PAUSE_DEC: assert property (
		slot_tick && !pause_frame_sent && pause_q != 16'h0000 |=>
		pause_q == $past(pause_q) - 16'h0001)
		else $error("Pause decrement wrong");
	AST_PAUSE_AGAIN: assert property (
		pause_expires ##1 still_wanted |=> pause_frame_req)
		else $error("No repeat pause request");
	AST_PAUSE_READ: assert property (
		rd_go && s_axi_araddr == mhb_pkg::PAUSE_OBS_OFS |=>
		s_axi_rdata == {16'h0000, $past(pause_q)})
		else $error("Pause read wrong");

endmodule : mhb_top

// ==== bench/mhb_phy_model.sv ====
// Purpose: Far-side stand-in: bit timing and the pause frame sender
// Assumes: One clock, srst synchronous and active high
// Notes:   slow adds latency before a requested pause frame goes out
`timescale 1ns/1ns
module mhb_phy_model #(
	parameter int TICK = 2
) (
	input  wire logic core_clk,
	input  wire logic srst,
	input  wire logic slow,
	input  wire logic pause_frame_req,
	output logic      tx_bit_tick,
	output logic      pause_frame_sent
);
	// ****************************************************************
	// Bit timing and pause frames
	// ****************************************************************
	int cnt_q;
	// One tick per bit time; the slot is counted from these
	always_ff @(posedge core_clk) begin
		if (srst) begin
			cnt_q       <= 0;
			tx_bit_tick <= 1'b0;
		end else begin
			cnt_q       <= (cnt_q == TICK - 1) ? 0 : cnt_q + 1;
			tx_bit_tick <= (cnt_q == TICK - 1);
		end
	end
	// Sends each pause frame asked for, then reports it
	initial begin
		pause_frame_sent = 1'b0;
		forever begin
			@(negedge core_clk);
			if (pause_frame_req && !srst) begin
				repeat (slow ? 6 : 1) @(posedge core_clk);
				pause_frame_sent <= 1'b1;
				@(posedge core_clk);
				pause_frame_sent <= 1'b0;
				repeat (2) @(posedge core_clk);
			end
		end
	end
endmodule : mhb_phy_model

// ==== bench/tb.sv ====
// Purpose: Self-checking bench for hash, backoff, pacing and pause
// Assumes: SLOT_BITS 8 and a bit tick every 2 clocks: slot of 16 clocks
// Notes:   Expectations come from the bench model; backoff and pause step checks start from read values
`timescale 1ns/1ns
module tb;
	localparam int SLOT = 16;
	logic        core_clk, srst, slow;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
	logic [47:0] rx_dest_addr;
	logic [5:0]  rx_hash_index;
	logic        rx_addr_valid, rx_hash_accept, tx_bit_tick, tx_collision;
	logic        tx_deferral, tx_frame_good, tx_frame_done, backoff_active;
	logic        pacing_active, ipg_stretch, rx_congested, pause_frame_sent;
	logic        pause_frame_req;
	logic [31:0] hash_m [2];
	int          err_count, tests_run, pace_m, b1;

	mhb_top #(.SLOT_BITS(8)) mhb_top_i (
		.core_clk(core_clk), .srst(srst),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .rx_dest_addr(rx_dest_addr),
		.rx_addr_valid(rx_addr_valid), .rx_hash_accept(rx_hash_accept),
		.rx_hash_index(rx_hash_index), .tx_bit_tick(tx_bit_tick),
		.tx_collision(tx_collision), .tx_deferral(tx_deferral),
		.tx_frame_good(tx_frame_good), .tx_frame_done(tx_frame_done),
		.backoff_active(backoff_active), .pacing_active(pacing_active),
		.ipg_stretch(ipg_stretch), .rx_congested(rx_congested),
		.pause_frame_sent(pause_frame_sent),
		.pause_frame_req(pause_frame_req)
	);
	mhb_phy_model mhb_phy_model_i (
		.core_clk(core_clk), .srst(srst), .slow(slow),
		.pause_frame_req(pause_frame_req), .tx_bit_tick(tx_bit_tick),
		.pause_frame_sent(pause_frame_sent)
	);

	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic chk(input string nm, input logic [31:0] e,
			input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic near(input string nm, input int lo, input int hi,
			input logic [31:0] g);
		chk(nm, 1, (g >= lo && g <= hi));
	endtask : near

	task automatic summarize();
		$display("Checks %0d, mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : summarize

	// Handshakes are judged at the falling edge, where nothing moves
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
			input logic [3:0] s);
		logic ah, wh, bh;
		@(posedge core_clk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_wstrb   <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		for (int i = 0; i < 50; i++) begin
			@(negedge core_clk);
			ah = s_axi_awvalid & s_axi_awready;
			wh = s_axi_wvalid & s_axi_wready;
			bh = s_axi_bvalid;
			rs = s_axi_bresp;
			@(posedge core_clk);
			if (ah) s_axi_awvalid <= 1'b0;
			if (wh) s_axi_wvalid <= 1'b0;
			if (bh) begin
				s_axi_bready <= 1'b0;
				return;
			end
		end
		chk("write answer", 1, 0);
	endtask : wr

	task automatic rdr(input logic [7:0] a);
		logic ah, rh;
		@(posedge core_clk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		for (int i = 0; i < 50; i++) begin
			@(negedge core_clk);
			ah = s_axi_arvalid & s_axi_arready;
			rh = s_axi_rvalid;
			rd = s_axi_rdata;
			rs = s_axi_rresp;
			@(posedge core_clk);
			if (ah) s_axi_arvalid <= 1'b0;
			if (rh) begin
				s_axi_rready <= 1'b0;
				return;
			end
		end
		chk("read answer", 1, 0);
	endtask : rdr

	task automatic hwr(input int w, input logic [31:0] d, input logic [3:0] s);
		wr(8'(4 * w), d, s);
		for (int b = 0; b < 4; b++) if (s[b]) hash_m[w][8*b +: 8] = d[8*b +: 8];
		chk("hash write resp", mhb_pkg::RESP_OKAY, rs);
		rdr(8'(4 * w));
		chk("hash word", hash_m[w], rd);
	endtask : hwr

	task automatic hchk(input logic [47:0] a);
		logic [5:0] h;
		h = 6'h00;
		for (int j = 0; j < 48; j++) h[j % 6] ^= a[j];
		@(posedge core_clk);
		rx_dest_addr  <= a;
		rx_addr_valid <= 1'b1;
		@(posedge core_clk);
		rx_addr_valid <= 1'b0;
		@(negedge core_clk);
		chk("hash index", h, rx_hash_index);
		chk("hash accept", a[0] & hash_m[h[5]][h[4:0]], rx_hash_accept);
	endtask : hchk

	// Kind 0 collision, 1 deferral, 2 clean frame, 3 attempt over
	task automatic ev(input int k);
		@(posedge core_clk);
		tx_collision  <= (k == 0);
		tx_deferral   <= (k == 1);
		tx_frame_good <= (k == 2);
		tx_frame_done <= (k == 3);
		@(posedge core_clk);
		{tx_collision, tx_deferral, tx_frame_good, tx_frame_done} <= 4'h0;
		@(negedge core_clk);
	endtask : ev

	task automatic pchk(input logic c);
		rdr(mhb_pkg::PACE_OBS_OFS);
		chk("pacing value", pace_m, rd);
		chk("pacing active", pace_m != 0, pacing_active);
		chk("gap stretch", c && pace_m != 0, ipg_stretch);
	endtask : pchk

	// ****************************************************************
	// Sequence
	// ****************************************************************
	initial begin
		{srst, slow, rx_congested} = 3'b100;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
		{s_axi_arvalid, s_axi_rready, rx_addr_valid} = 3'b000;
		{tx_collision, tx_deferral, tx_frame_good, tx_frame_done} = 4'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		rx_dest_addr = '0;
		hash_m = '{32'h0, 32'h0};
		void'($urandom(32'h4e543ce8));
		repeat (20) @(posedge core_clk);
		srst <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			rdr(8'(4 * i));
			chk("reset value", 0, rd & 32'hfc00_ffff);
		end
		rdr(mhb_pkg::BOFF_OBS_OFS);
		b1 = rd[25:16];
		rdr(mhb_pkg::BOFF_OBS_OFS);
		chk("random moves", 1, rd[25:16] != b1);
		rdr(8'h18);
		chk("unmapped resp", mhb_pkg::RESP_SLVERR, rs);
		chk("unmapped data", 0, rd);
		wr(mhb_pkg::BOFF_OBS_OFS, 32'hffff_ffff, 4'hf);
		chk("read-only write", mhb_pkg::RESP_SLVERR, rs);
		hwr(0, $urandom, 4'hf);
		hwr(1, $urandom, 4'hf);
		hwr(0, $urandom, 4'h5);
		for (int i = 0; i < 48; i++) hchk({16'($urandom), $urandom} | 48'(i % 4 != 0));
		for (int k = 1; k <= 16; k++) begin
			ev(0);
			rdr(mhb_pkg::BOFF_OBS_OFS);
			chk("collisions", (k > 15) ? 15 : k, rd[15:12]);
			near("backoff load", 0, (1 << ((k > 10) ? 10 : k)) - 1, rd[9:0]);
		end
		b1 = rd[9:0];
		repeat (8 * SLOT) @(posedge core_clk);
		rdr(mhb_pkg::BOFF_OBS_OFS);
		if (b1 > 10) near("backoff step", b1 - 9, b1 - 7, rd[9:0]);
		for (int i = 0; i < 1100 * SLOT && backoff_active; i++) @(negedge core_clk);
		rdr(mhb_pkg::BOFF_OBS_OFS);
		chk("backoff spent", 0, {backoff_active, rd[9:0]});
		ev(3);
		rdr(mhb_pkg::BOFF_OBS_OFS);
		chk("collisions cleared", 0, rd[15:12]);
		pace_m = 31;
		pchk(1'b0);
		for (int i = 0; i < 36; i++) begin
			ev((i == 3) ? 1 : 2);
			pace_m = (i == 3) ? 31 : ((pace_m > 0) ? pace_m - 1 : 0);
			pchk(i != 3);
		end
		@(posedge core_clk);
		rx_congested <= 1'b1;
		slow         <= 1'b1;
		repeat (8) @(posedge core_clk);
		chk("pause held off", 0, pause_frame_req);
		wr(mhb_pkg::CTRL_OFS, 32'h1, 4'h1);
		for (int i = 0; i < 40 && !pause_frame_sent; i++) @(negedge core_clk);
		repeat (3) @(negedge core_clk);
		chk("pause request off", 0, pause_frame_req);
		rdr(mhb_pkg::PAUSE_OBS_OFS);
		near("pause load", 32'hfefe, 32'hff00, rd);
		b1 = rd;
		repeat (20 * SLOT) @(posedge core_clk);
		rdr(mhb_pkg::PAUSE_OBS_OFS);
		near("pause step", b1 - 21, b1 - 19, rd);
		@(posedge core_clk);
		rx_congested <= 1'b0;
		wr(mhb_pkg::CTRL_OFS, 32'h0, 4'h1);
		summarize();
	end

	initial begin
		repeat (60000) @(posedge core_clk);
		err_count++;
		$display("[FAIL] watchdog expected finish seen hang");
		summarize();
	end
endmodule : tb
